/* File: hw/rst_seq_pkg.sv */
// constants and types shared by the reset and start-up sequencer
package rst_seq_pkg;

  // clock and start-up timing
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned STARTUP_WAIT_MS  = 18;
  localparam int unsigned STARTUP_CYCLES   = STARTUP_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned STARTUP_CNT_W    = 32;

  // program counter
  localparam int unsigned PC_W             = 10;
  localparam logic [9:0]  RESET_VECTOR     = 10'h000;

  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_DEPTH       = 3;

  // apb register map
  localparam logic [7:0]  ADDR_CAUSE       = 8'h00;
  localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h08;
  localparam logic [7:0]  ADDR_CTRL        = 8'h0C;

  // cause register fields
  localparam int unsigned BIT_DOG_EXPIRY   = 0;
  localparam int unsigned BIT_SLEEP_ENTRY  = 1;
  localparam int unsigned BIT_CAUSE_POR    = 2;
  localparam int unsigned BIT_CAUSE_DROP   = 3;
  localparam int unsigned BIT_CAUSE_DOG    = 4;
  localparam int unsigned BIT_RUNNING      = 5;

  // interrupt event fields
  localparam int unsigned IRQ_W            = 4;
  localparam int unsigned EV_DROP          = 0;
  localparam int unsigned EV_DOG           = 1;
  localparam int unsigned EV_WAKE          = 2;
  localparam int unsigned EV_RELEASE       = 3;

  // control fields
  localparam int unsigned BIT_DROP_EN      = 0;
  localparam logic [1:0]  CTRL_RESET       = 2'h1;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_SLEEP = 2'b10
  } seq_state_t;

endpackage

/* File: hw/pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);
  import rst_seq_pkg::*;

  logic [SYNC_DEPTH-1:0] sh_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q  <= '0;
      level <= 1'b0;
    end else begin
      sh_q <= {sh_q[SYNC_DEPTH-2:0], pin};
      // first stage feeds only the second; change counts once stages two and three agree
      if (sh_q[1] == sh_q[2]) begin
        level <= sh_q[2];
      end
    end
  end

endmodule

/* File: hw/reset_and_startup_sequencer.sv */
// reset and start-up sequencer with apb status and control
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
//
// Summary of operation
// RULE1 - every reset waits a fixed 18 ms start-up before the core runs
// RULE2 - three reset sources: power-on, supply drop when enabled, watchdog overflow while running
// RULE3 - any reset holds system registers at defaults, halts core, clears program counter
// RULE4 - after the sequence the core fetches from reset vector 0000H
// RULE5 - two readable flags tell which kind of reset happened
// RULE6 - power-on: supply settles, registers initialise, oscillator starts, program runs
// RULE7 - enabled supply-drop detector below threshold triggers full system reset
// RULE8 - watchdog overflow during normal operation resets whole system
// RULE9 - watchdog reset: detect overflow, defaults, oscillator start, then run
// RULE10 - watchdog-caused reset clears the watchdog expiry flag
// RULE11 - while asleep, watchdog overflow or interrupt wakes without reset, resumes after halt
// RULE12 - start-up timed by a counter, core released synchronously to the system clock
module reset_and_startup_sequencer #(
  parameter int unsigned STARTUP_COUNT = rst_seq_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // reset sources, asynchronous pins
  input  wire logic                  supply_ok,
  input  wire logic                  supply_drop_reset,
  input  wire logic                  watchdog_counter_ovf,
  // core side, same clock
  input  wire logic                  sleep_req,
  input  wire logic                  wake_irq,
  output logic                       core_rst_n,
  output logic                       sys_regs_rst_n,
  output logic                       osc_en,
  output logic                       core_stall,
  output logic [rst_seq_pkg::PC_W-1:0] pc_load,
  output logic                       pc_load_en,
  output logic                       irq
);
  import rst_seq_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  logic                 supply_ok_s;
  logic                 drop_s;
  logic                 dog_s;
  seq_state_t           state_q;
  seq_state_t           state_d;
  logic [STARTUP_CNT_W-1:0] cnt_q;
  logic                 dog_expiry_flag_q;
  logic                 sleep_entry_flag_q;
  logic [2:0]           cause_q;
  logic [2:0]           cause_d;
  logic [1:0]           ctrl_q;
  logic [IRQ_W-1:0]     stat_q;
  logic [IRQ_W-1:0]     mask_q;
  logic                 dog_prev_q;
  logic                 drop_prev_q;
  logic                 wake_pc_q;

  pin_sync u_sync_supply (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (supply_ok),
    .level   (supply_ok_s)
  );
  pin_sync u_sync_drop (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (supply_drop_reset),
    .level   (drop_s)
  );
  pin_sync u_sync_dog (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (watchdog_counter_ovf),
    .level   (dog_s)
  );

  // apb decode
  wire wr_en     = psel && penable && pwrite;
  wire rd_en     = psel && penable && !pwrite;
  wire sel_cause = hit(paddr, ADDR_CAUSE);
  wire sel_stat  = hit(paddr, ADDR_IRQ_STAT);
  wire sel_mask  = hit(paddr, ADDR_IRQ_MASK);
  wire sel_ctrl  = hit(paddr, ADDR_CTRL);
  wire mapped    = sel_cause || sel_stat || sel_mask || sel_ctrl;

  // edge events, so a stuck level counts once
  wire dog_edge  = dog_s && !dog_prev_q;
  wire drop_edge = drop_s && !drop_prev_q;

  // reset sources
  wire src_por   = !supply_ok_s;                                      // RULE2 RULE6
  wire src_drop  = drop_s && ctrl_q[BIT_DROP_EN];                     // RULE2 RULE7
  wire src_dog   = dog_edge && (state_q == ST_RUN);                   // RULE2 RULE8
  wire any_reset = src_por || src_drop || src_dog;
  wire wake      = (state_q == ST_SLEEP) && (dog_edge || wake_irq);   // RULE11
  wire cnt_done  = cnt_q >= STARTUP_CNT_W'(STARTUP_COUNT - 1);
  // resume path keeps the core out of reset; any new reset source cancels it at once
  wire resume    = (wake_pc_q || wake) && (state_d != ST_HOLD);       // RULE11

  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    if (src_por) begin
      state_d = ST_HOLD;
      cause_d = 3'b001;
    end else if (src_drop) begin
      state_d = ST_HOLD;
      cause_d = 3'b010;
    end else if (src_dog) begin
      state_d = ST_HOLD;                                              // RULE9
      cause_d = 3'b100;
    end else begin
      case (state_q)
        ST_HOLD:  state_d = ST_WAIT;                                  // RULE6 RULE9
        ST_WAIT:  state_d = cnt_done ? ST_RUN : ST_WAIT;              // RULE1
        ST_RUN:   state_d = sleep_req ? ST_SLEEP : ST_RUN;
        ST_SLEEP: state_d = wake ? ST_WAIT : ST_SLEEP;                // RULE11
        default:  state_d = ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_HOLD;
      cause_q <= 3'b001;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  // start-up counter; cleared on entry, counts in wait only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q != ST_WAIT) begin
      cnt_q <= '0;
    end else if (!cnt_done) begin
      cnt_q <= cnt_q + 1'b1;                                          // RULE1 RULE12
    end
  end

  // flags: active-low expiry like the classic status bit, 1 means no overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_expiry_flag_q  <= 1'b1;
      sleep_entry_flag_q <= 1'b1;
      wake_pc_q          <= 1'b0;
      dog_prev_q         <= 1'b0;
      drop_prev_q        <= 1'b0;
    end else begin
      dog_prev_q  <= dog_s;
      drop_prev_q <= drop_s;
      if (src_por) begin
        dog_expiry_flag_q  <= 1'b1;                                   // RULE5
        sleep_entry_flag_q <= 1'b1;
      end else if (src_dog || (wake && dog_edge)) begin
        dog_expiry_flag_q  <= 1'b0;                                   // RULE10
      end
      if (state_q == ST_RUN && state_d == ST_SLEEP) begin
        sleep_entry_flag_q <= 1'b0;                                   // RULE5
      end
      if (any_reset) begin
        wake_pc_q <= 1'b0;
      end else if (wake) begin
        wake_pc_q <= 1'b1;
      end
    end
  end

  // control register; supply-drop enable stands in for the config option
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && sel_ctrl) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // interrupt status, set wins; a read clears only the bits it reported, so a setup-cycle event survives
  wire [IRQ_W-1:0] ev = {(state_q == ST_WAIT) && cnt_done, wake, src_dog, drop_edge && ctrl_q[BIT_DROP_EN]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((rd_en && sel_stat) ? prdata[IRQ_W-1:0] : '0)) | ev;
      if (wr_en && sel_mask) begin
        mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // read data from flops
  wire [31:0] rd_mux =
    sel_cause ? {26'h0, (state_q == ST_RUN), cause_q, sleep_entry_flag_q, dog_expiry_flag_q} :
    sel_stat  ? {28'h0, stat_q} :
    sel_mask  ? {28'h0, mask_q} :
    sel_ctrl  ? {30'h0, ctrl_q} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq     = |(stat_q & mask_q);

  // core outputs, all synchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rst_n     <= 1'b0;
      sys_regs_rst_n <= 1'b0;
      osc_en         <= 1'b0;
      core_stall     <= 1'b1;
      pc_load        <= RESET_VECTOR;
      pc_load_en     <= 1'b1;
    end else begin
      sys_regs_rst_n <= (state_d != ST_HOLD);                         // RULE3
      core_rst_n     <= (state_d == ST_RUN) || (state_d == ST_SLEEP) || resume; // RULE12
      osc_en         <= (state_d != ST_HOLD) && (state_d != ST_SLEEP); // RULE6 RULE9
      core_stall     <= (state_d != ST_RUN);
      pc_load        <= RESET_VECTOR;                                 // RULE3 RULE4
      pc_load_en     <= (state_d == ST_HOLD) || ((state_d == ST_WAIT) && !resume);
    end
  end

  // checks
  property p_wait_full;
    @(posedge pclk) disable iff (!presetn)
      $rose(state_q == ST_RUN) |-> $past(cnt_done);
  endproperty
  a_wait_full: assert property (p_wait_full) else $error("run entered before start-up count"); // RULE1

  property p_dog_resets;
    @(posedge pclk) disable iff (!presetn)
      src_dog |=> state_q == ST_HOLD && !sys_regs_rst_n;
  endproperty
  a_dog_resets: assert property (p_dog_resets) else $error("watchdog overflow did not reset"); // RULE8

  property p_hold_regs;
    @(posedge pclk) disable iff (!presetn)
      state_q == ST_HOLD |-> !sys_regs_rst_n && !core_rst_n && pc_load_en;
  endproperty
  a_hold_regs: assert property (p_hold_regs) else $error("hold did not reset registers"); // RULE3

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
      pc_load_en |-> pc_load == RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector wrong"); // RULE4

  property p_expiry;
    @(posedge pclk) disable iff (!presetn)
      src_dog |=> !dog_expiry_flag_q;
  endproperty
  a_expiry: assert property (p_expiry) else $error("expiry flag not cleared"); // RULE10

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
      drop_s && ctrl_q[BIT_DROP_EN] |=> state_q == ST_HOLD;
  endproperty
  a_drop: assert property (p_drop) else $error("enabled supply drop did not reset"); // RULE7

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      wake && !src_por && !src_drop |=> state_q == ST_WAIT ##1 (!pc_load_en)[*2];
  endproperty
  a_wake: assert property (p_wake) else $error("wake reloaded reset vector"); // RULE11

  property p_osc_order;
    @(posedge pclk) disable iff (!presetn)
      $rose(core_rst_n) && !$past(wake_pc_q) |-> $past(osc_en, 2);
  endproperty
  a_osc_order: assert property (p_osc_order) else $error("core released before oscillator"); // RULE6

  property p_wake_keeps_core;
    @(posedge pclk) disable iff (!presetn)
      wake && !src_por && !src_drop |=> core_rst_n;
  endproperty
  a_wake_keeps_core: assert property (p_wake_keeps_core) else $error("wake pulled core into reset"); // RULE11

  property p_run_release;
    @(posedge pclk) disable iff (!presetn)
      state_q == ST_RUN |-> core_rst_n && !core_stall && !pc_load_en;
  endproperty
  a_run_release: assert property (p_run_release) else $error("core not released in run"); // RULE12

  property p_por_flags;
    @(posedge pclk) disable iff (!presetn)
      src_por |=> state_q == ST_HOLD && dog_expiry_flag_q && sleep_entry_flag_q;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on did not set both flags"); // RULE5

endmodule

/* File: tb/core_model.sv */
// behavioural core that asks for sleep and raises wake interrupts
`timescale 1ns/1ps
module core_model (
  // clock
  input  wire logic pclk,
  // commands from the bench
  input  wire logic go_sleep,
  input  wire logic go_wake,
  // sequencer side
  input  wire logic core_rst_n,
  input  wire logic core_stall,
  output logic      sleep_req,
  output logic      wake_irq
);
  initial begin
    sleep_req = 1'b0;
    wake_irq  = 1'b0;
  end
  // a stalled or reset core cannot execute the halt, so sleep is asked only while running
  always @(posedge pclk) begin
    sleep_req <= go_sleep && core_rst_n && !core_stall;
    wake_irq  <= go_wake && core_stall;
  end
endmodule

/* File: tb/reset_and_startup_sequencer_tb.sv */
// self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITV(s, v) begin k = 0; while ((s) !== (v) && k < 100) begin @(posedge pclk); k++; end \
  if ((s) !== (v)) miscompares++; end
module reset_and_startup_sequencer_tb;
  import rst_seq_pkg::*;
  localparam int unsigned SC = 20;
  logic            pclk, presetn, psel, penable, pwrite, supply_ok, drop, ovf, go_sleep, go_wake, er;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, rd;
  logic [3:0]      m;
  wire  [31:0]     prdata;
  wire             pready, pslverr, sleep_req, wake_irq, core_rst_n, sys_regs_rst_n;
  wire             osc_en, core_stall, pc_load_en, irq;
  wire  [PC_W-1:0] pc_load;
  int              k, n, miscompares, n_checks;

  always #4 pclk = ~pclk;

  reset_and_startup_sequencer #(.STARTUP_COUNT(SC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(supply_ok), .supply_drop_reset(drop), .watchdog_counter_ovf(ovf),
    .sleep_req(sleep_req), .wake_irq(wake_irq), .core_rst_n(core_rst_n),
    .sys_regs_rst_n(sys_regs_rst_n), .osc_en(osc_en), .core_stall(core_stall),
    .pc_load(pc_load), .pc_load_en(pc_load_en), .irq(irq));

  core_model i_core (.pclk(pclk), .go_sleep(go_sleep), .go_wake(go_wake), .core_rst_n(core_rst_n),
    .core_stall(core_stall), .sleep_req(sleep_req), .wake_irq(wake_irq));

  // cause field: running above a one-hot of por, drop, dog
  function automatic logic [3:0] cause_exp(input int src);
    return 4'h8 | (4'h1 << src);
  endfunction

  // interrupt status after a reset: start-up done, plus watchdog reset or enabled drop edge
  function automatic logic [3:0] stat_exp(input int src);
    return 4'h8 | ((src == 2) ? 4'h2 : (src == 1) ? 4'h1 : 4'h0);
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // oscillator must run before the core leaves reset
  task automatic boot();
    `WAITV(sys_regs_rst_n, 1'b1)
    @(posedge pclk);
    `CHK({core_rst_n, osc_en}, 2'b01)
    n = 0;
    while (core_rst_n !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n + 1 >= SC && n <= SC + 2, 1'b1)
    `CHK({pc_load_en, core_stall}, 2'b00)
  endtask

  task automatic hit(input int src);
    if (src == 2) ovf <= 1'b1;
    else if (src == 1) drop <= 1'b1;
    else supply_ok <= 1'b0;
    `WAITV(core_rst_n, 1'b0)
    `CHK({sys_regs_rst_n, pc_load_en, core_stall, pc_load}, {3'b011, RESET_VECTOR})
    // level sources are held a while; the watchdog event is a pulse, so boot timing starts at once
    if (src != 2) repeat (6) @(posedge pclk);
    ovf       <= 1'b0;
    drop      <= 1'b0;
    supply_ok <= 1'b1;
    boot();
    apb(1'b0, ADDR_CAUSE, 32'h0);
    `CHK(rd[5:2], cause_exp(src))
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK(rd[3:0], stat_exp(src))
  endtask

  initial begin
    #(8 * 8000);
    miscompares++;
    wrap_up();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, supply_ok, drop, ovf, go_sleep, go_wake} = 10'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'hCD13));
    repeat (6) @(posedge pclk);
    `CHK({core_rst_n, sys_regs_rst_n, pc_load_en, irq}, 4'b0010)
    presetn   <= 1'b1;
    supply_ok <= 1'b1;
    boot();
    apb(1'b0, ADDR_CAUSE, 32'h0);
    `CHK(rd[5:0], {cause_exp(0), 2'b11})
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd[1:0], CTRL_RESET)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    `CHK(irq, 1'b0)
    m = 4'($urandom_range(15, 0)) | 4'h8;
    apb(1'b1, ADDR_IRQ_MASK, {28'h0, m});
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    `CHK(rd[3:0], m)
    `CHK(irq, 1'b1)
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK(rd[3], 1'b1)
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK({rd[3:0], irq}, 5'h00)
    hit(2);
    `CHK(rd[0], 1'b0)
    hit(1);
    hit(0);
    // a disabled detector must leave the core running
    apb(1'b1, ADDR_CTRL, 32'h0);
    drop <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(core_rst_n, 1'b1)
    drop <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      go_sleep <= 1'b1;
      `WAITV(core_stall, 1'b1)
      go_sleep <= 1'b0;
      repeat ($urandom_range(8, 2)) @(posedge pclk);
      if (i == 0) ovf <= 1'b1;
      else go_wake <= 1'b1;
      `WAITV(core_stall, 1'b0)
      ovf     <= 1'b0;
      go_wake <= 1'b0;
      `CHK(core_rst_n, 1'b1)
      apb(1'b0, ADDR_CAUSE, 32'h0);
      `CHK(rd[5:0], {cause_exp(0), 2'b00})
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK(rd[3:0], 4'hC)
    end
    wrap_up();
  end
endmodule
